// ==== shared/driver_fault_status_consts.vh ====
// constants for the driver status flag block
`ifndef DRIVER_FAULT_STATUS_CONSTS_VH
`define DRIVER_FAULT_STATUS_CONSTS_VH
`define FAULT_STATUS_ADDR   7'h6F
`define STST_CYCLES         21'h100000
`define STST_CNT_W          21
`define BIT_STST            31
`define BIT_QUIET           30
`define CS_HI               20
`define CS_LO               16
`define BIT_TEMP_LO         8
`define BIT_OPEN_A          6
`define BIT_LSS_A           4
`define BIT_GND_A           2
`define BIT_OT              1
`define BIT_OTPW            0
`endif

// ==== design/short_flag_pair.v ====
// sticky short flags for one chopper mode
`timescale 1ns/10ps
`default_nettype none
`include "driver_fault_status_consts.vh"
module short_flag_pair (
    input  wire       clock,
    input  wire       rst_n,
    input  wire       active,
    input  wire       clear,
    input  wire [3:0] detect,
    output reg  [3:0] flags_q
);
    // detection only counts while this mode drives; clear by disabling
    always @(posedge clock) begin
        if (!rst_n) begin
            flags_q <= 4'h0;
        end else if (clear) begin
            flags_q <= 4'h0;
        end else begin
            flags_q <= flags_q | (detect & {4{active}});
        end
    end
endmodule
`default_nettype wire

// ==== design/driver_status_flags.v ====
// driver status word: standstill, mode, current scale and fault flags
// Functional notes
// - standstill bit 31 set after 2^20 clocks without step, cleared on step
// - bit 30 high while quiet voltage-mode chopper is active
// - bits 20..16 show the applied current scale
// - bits 11..8 follow the 157/150/143/120 degree comparators
// - bits 7,6 show open load on B,A; no protective action
// - bits 5,4 latch low-side shorts B,A and disable bridges
// - bits 3,2 latch ground shorts B,A and disable bridges
// - short flags hold until off-time zero or enable input high
// - separate short flag sets kept per chopper mode
// - bit 1 over-temperature; bridges off until pre-warning also clears
// - bit 0 set while pre-warning threshold exceeded
// - one over-temperature and one pre-warning flag for both bridges
`timescale 1ns/10ps
`default_nettype none
`include "driver_fault_status_consts.vh"
module driver_status_flags (
    input  wire        clock,
    input  wire        rst_n,
    input  wire        step_in,
    input  wire        quiet_mode,
    input  wire [4:0]  current_scale,
    input  wire [3:0]  temp_comp_in,
    input  wire [1:0]  open_load_in,
    input  wire [1:0]  lowside_short_in,
    input  wire [1:0]  ground_short_in,
    input  wire        over_temp_in,
    input  wire        pre_warn_in,
    input  wire        enable_low_input,
    input  wire [3:0]  chopper_off_time,
    input  wire [6:0]  reg_addr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata_q,
    output wire        bridge_enable
);
    reg  [2:0]  step_s_q;
    reg  [1:0]  enn_s_q;
    reg  [3:0]  tc_s1_q, tc_q;
    reg  [1:0]  ol_s1_q, ol_q;
    reg  [3:0]  sh_s1_q, sh_q;
    reg  [1:0]  ot_s1_q, ot_q;
    reg  [`STST_CNT_W-1:0] idle_q;
    reg         stst_q;
    reg         ot_lock_q;
    wire [3:0]  flags_quiet;
    wire [3:0]  flags_cycle;
    wire [3:0]  short_view;
    wire        step_edge;
    wire        drv_off;
    // pin synchronisers, two stages before use
    always @(posedge clock) begin
        if (!rst_n) begin
            step_s_q <= 3'h0;
            enn_s_q  <= 2'h3;
            tc_s1_q  <= 4'h0;
            tc_q     <= 4'h0;
            ol_s1_q  <= 2'h0;
            ol_q     <= 2'h0;
            sh_s1_q  <= 4'h0;
            sh_q     <= 4'h0;
            ot_s1_q  <= 2'h0;
            ot_q     <= 2'h0;
        end else begin
            step_s_q <= {step_s_q[1:0], step_in};
            enn_s_q  <= {enn_s_q[0], enable_low_input};
            tc_s1_q  <= temp_comp_in;
            tc_q     <= tc_s1_q;
            ol_s1_q  <= open_load_in;
            ol_q     <= ol_s1_q;
            sh_s1_q  <= {lowside_short_in, ground_short_in};
            sh_q     <= sh_s1_q;
            ot_s1_q  <= {over_temp_in, pre_warn_in};
            ot_q     <= ot_s1_q;
        end
    end
    assign step_edge = step_s_q[1] & ~step_s_q[2];
    // driver disabled by software off-time zero or enable pin high
    assign drv_off = enn_s_q[1] | (chopper_off_time == 4'h0);
    // standstill counter, independent of chopper mode
    always @(posedge clock) begin
        if (!rst_n) begin
            idle_q <= {`STST_CNT_W{1'b0}};
            stst_q <= 1'b0;
        end else if (step_edge) begin
            idle_q <= {`STST_CNT_W{1'b0}};
            stst_q <= 1'b0;
        end else if (idle_q == `STST_CYCLES - 21'h1) begin
            stst_q <= 1'b1;
        end else begin
            idle_q <= idle_q + 21'h1;
        end
    end
    // one sticky short set per chopper mode
    short_flag_pair u_quiet (
        .clock   (clock),
        .rst_n   (rst_n),
        .active  (quiet_mode),
        .clear   (drv_off),
        .detect  (sh_q),
        .flags_q (flags_quiet)
    );
    short_flag_pair u_cycle (
        .clock   (clock),
        .rst_n   (rst_n),
        .active  (~quiet_mode),
        .clear   (drv_off),
        .detect  (sh_q),
        .flags_q (flags_cycle)
    );
    assign short_view = quiet_mode ? flags_quiet : flags_cycle;
    // thermal shutdown held until pre-warning drops too, shared by bridges
    always @(posedge clock) begin
        if (!rst_n) begin
            ot_lock_q <= 1'b0;
        end else if (ot_q[1]) begin
            ot_lock_q <= 1'b1;
        end else if (!ot_q[0]) begin
            ot_lock_q <= 1'b0;
        end
    end
    // open load takes no part in the bridge enable
    assign bridge_enable = ~drv_off & ~ot_lock_q & ~(|flags_quiet) & ~(|flags_cycle);
    // read port: only this address answers, reads change no state
    always @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata_q <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata_q <= 32'h00000000;
            if (reg_addr == `FAULT_STATUS_ADDR) begin
                reg_rdata_q[`BIT_STST]                <= stst_q;
                reg_rdata_q[`BIT_QUIET]               <= quiet_mode;
                reg_rdata_q[`CS_HI:`CS_LO]            <= current_scale;
                reg_rdata_q[`BIT_TEMP_LO+3:`BIT_TEMP_LO] <= tc_q;
                reg_rdata_q[`BIT_OPEN_A+1:`BIT_OPEN_A] <= ol_q;
                reg_rdata_q[`BIT_LSS_A+1:`BIT_LSS_A]  <= short_view[3:2];
                reg_rdata_q[`BIT_GND_A+1:`BIT_GND_A]  <= short_view[1:0];
                reg_rdata_q[`BIT_OT]                  <= ot_lock_q;
                reg_rdata_q[`BIT_OTPW]                <= ot_q[0];
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/host_reader.sv ====
// host model reading status registers
`timescale 1ns/10ps
`default_nettype none
module host_reader (
    input  wire logic        clock,
    output var  logic [6:0]  reg_addr,
    output var  logic        reg_rd,
    input  wire logic [31:0] reg_rdata_q
);
    initial {reg_addr, reg_rd} = 8'h00;
    // request one edge, take data one edge later
    task automatic read(input logic [6:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        @(posedge clock);
        d = reg_rdata_q;
    endtask
endmodule
`default_nettype wire

// ==== tb/status_checker.sv ====
// assertions on the status word
`timescale 1ns/10ps
`default_nettype none
module status_checker (
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        quiet_mode,
    input wire logic [4:0]  current_scale,
    input wire logic [3:0]  temp_comp_in,
    input wire logic [1:0]  open_load_in,
    input wire logic        over_temp_in,
    input wire logic        pre_warn_in,
    input wire logic [6:0]  reg_addr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata_q,
    input wire logic        bridge_enable
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic        rd = reg_rd && reg_addr == 7'h6F;
    wire logic [31:0] q = reg_rdata_q;
    a_other_addr: assert property (reg_rd && !rd |=> q == 32'h0) else $error("other address");
    a_mode_bit: assert property ($stable(quiet_mode)[*5] ##0 rd |=> q[30] == $past(quiet_mode)) else $error("mode");
    a_scale_field: assert property ($stable(current_scale)[*5] ##0 rd |=> q[20:16] == $past(current_scale))
        else $error("scale");
    a_temp_field: assert property ($stable(temp_comp_in)[*5] ##0 rd |=> q[11:8] == $past(temp_comp_in))
        else $error("temp");
    a_open_field: assert property ($stable(open_load_in)[*5] ##0 rd |=> q[7:6] == $past(open_load_in))
        else $error("open load");
    a_warn_bit: assert property ($stable(pre_warn_in)[*5] ##0 rd |=> q[0] == $past(pre_warn_in)) else $error("warn");
    a_hot_off: assert property (over_temp_in[*5] |-> !bridge_enable) else $error("hot bridge");
    a_hot_bit: assert property (over_temp_in[*5] ##0 rd |=> q[1]) else $error("hot bit");
    c_read: cover property (rd && quiet_mode);
    c_other: cover property (reg_rd && !rd);
    c_lock: cover property (pre_warn_in && !bridge_enable);
endmodule
bind driver_status_flags status_checker status_checker_i (.*);
`default_nettype wire

// ==== tb/tb_driver_status_flags.sv ====
// testbench for the status word
`timescale 1ns/10ps
`default_nettype none
module tb_driver_status_flags;
    logic        clock, rst_n, step_in, quiet_mode, over_temp_in, pre_warn_in, enable_low_input, reg_rd, bridge_enable;
    logic [4:0]  current_scale;
    logic [3:0]  temp_comp_in, chopper_off_time;
    logic [1:0]  open_load_in, lowside_short_in, ground_short_in;
    logic [6:0]  reg_addr;
    logic [31:0] reg_rdata_q;
    int          err_count = 0;
    int          checked = 0;
    driver_status_flags driver_status_flags_i (.*);
    host_reader host_reader_i (.*);
    // 250 MHz clock
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // settle, read, compare masked word and bridge
    task automatic look(input logic [6:0] a, input logic [31:0] m, e, input logic b);
        logic [31:0] d;
        repeat (6) @(posedge clock);
        host_reader_i.read(a, d);
        checked++;
        if ({d & m, bridge_enable} !== {e, b}) begin
            err_count++;
            $display("unexpected word+bridge: expected %h seen %h", {e, b}, {d & m, bridge_enable});
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        {rst_n, step_in, quiet_mode, current_scale, temp_comp_in, open_load_in} = 14'h0000;
        {lowside_short_in, ground_short_in, over_temp_in, pre_warn_in, enable_low_input} = 7'h00;
        chopper_off_time = 4'h3;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        // fields in both modes, other address
        {step_in, quiet_mode, current_scale, temp_comp_in, open_load_in, pre_warn_in} <= 14'h3AD5;
        look(7'h6F, 32'hFFFFFFFF, 32'h40150A81, 1'b1);
        look(7'h6E, 32'hFFFFFFFF, 32'h0, 1'b1);
        {quiet_mode, current_scale, temp_comp_in, open_load_in, pre_warn_in} <= 13'h0AAA;
        look(7'h6F, 32'hFFFFFFFF, 32'h00150540, 1'b1);
        // shorts latch per mode, clear on zero off-time
        {lowside_short_in, ground_short_in} <= 4'h6;
        repeat (3) @(posedge clock);
        {lowside_short_in, ground_short_in} <= 4'h0;
        look(7'h6F, 32'h3C, 32'h18, 1'b0);
        quiet_mode <= 1'b1;
        look(7'h6F, 32'h3C, 32'h0, 1'b0);
        quiet_mode <= 1'b0;
        look(7'h6F, 32'h3C, 32'h18, 1'b0);
        chopper_off_time <= 4'h0;
        repeat (4) @(posedge clock);
        chopper_off_time <= 4'h3;
        look(7'h6F, 32'h3C, 32'h0, 1'b1);
        // other short pair, cleared by the enable pin
        {lowside_short_in, ground_short_in} <= 4'h9;
        repeat (3) @(posedge clock);
        {lowside_short_in, ground_short_in} <= 4'h0;
        look(7'h6F, 32'h3C, 32'h24, 1'b0);
        enable_low_input <= 1'b1;
        repeat (4) @(posedge clock);
        enable_low_input <= 1'b0;
        look(7'h6F, 32'h3C, 32'h0, 1'b1);
        // lockout held until pre-warning clears
        {over_temp_in, pre_warn_in} <= 2'h3;
        look(7'h6F, 32'h3, 32'h3, 1'b0);
        over_temp_in <= 1'b0;
        look(7'h6F, 32'h3, 32'h3, 1'b0);
        pre_warn_in <= 1'b0;
        look(7'h6F, 32'h3, 32'h0, 1'b1);
        stop_test();
    end
    // watchdog
    initial begin
        repeat (2000) @(posedge clock);
        err_count++;
        stop_test();
    end
endmodule
`default_nettype wire
